// ### dv/galias_checker.sv
`include "galias_regs.svh"

module galias_checker (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        rdEn,
  input wire logic        wrEn,
  input wire logic        secure,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] ackWord_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Last acknowledge word
  always_ff @(posedge core_clk) begin
    if (!rstn) ackWord_reg <= 13'h0000;
    else if (rvalid) ackWord_reg <= rdata[12:0];
  end
  a_read_answered: assert property (rdEn |=> rvalid) else $error("read unanswered");
  a_no_stray_answer: assert property (rvalid |-> $past(rdEn)) else $error("stray rvalid");
  a_reserved_zero: assert property (rvalid |-> rdata[31:13] == 19'h0) else $error("rsv");
  a_cpu_zero: assert property (rvalid && rdata[9:0] > 10'h00F |-> rdata[12:10] == 3'h0)
    else $error("cpu not zero");
  a_eoi_echo: assert property (wrEn |-> wdata[12:0] == ackWord_reg)
    else $error("eoi value");
  a_secure_only: assert property (rdEn || wrEn |-> secure) else $error("not secure");
  a_eoi_offset: assert property (wrEn |-> addr == `GALIAS_EOI_OFFSET) else $error("eoi addr");
  a_single_read: assert property (rdEn |=> !rdEn ##1 !wrEn) else $error("overlap");
endmodule

// ### dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, ackReq, eoiReq, pendValid, ackControl, secMode, primaryEoiWrite;
  logic ackPulse, dropPulse, deactPulse, group0DropPulse, busy, ackDone;
  logic [9:0] pendId, ackId, eoiId;
  logic [2:0] pendCpu, ackCpu, eoiCpu;
  logic [31:0] ackValue;
  int nAck, nDrop, nDeact, nG0, nDone, badCount, testsRun, cycles;
  galias_if bus();
  galias_device galias_device_inst (.core_clk, .rstn, .clkEn(1'b1), .bus(bus), .pendValid,
    .pendId, .pendCpu, .ackControl, .secureCompletionMode(secMode), .primaryEoiWrite,
    .ackPulse, .ackId, .ackCpu, .dropPulse, .deactPulse, .eoiId, .eoiCpu, .group0DropPulse);
  galias_host galias_host_inst (.core_clk, .rstn, .clkEn(1'b1), .bus(bus), .ackReq, .eoiReq,
    .busy, .ackDone, .ackValue);
  galias_checker galias_checker_inst (.core_clk, .rstn, .rdEn(bus.rdEn), .wrEn(bus.wrEn),
    .secure(bus.secure), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
    .rvalid(bus.rvalid));
  // Clock and pulse counters, hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    nAck += (ackPulse === 1'b1);
    nDrop += (dropPulse === 1'b1);
    nDeact += (deactPulse === 1'b1);
    nG0 += (group0DropPulse === 1'b1);
    nDone += (ackDone === 1'b1);
    cycles++;
    if (cycles == 2000) begin
      badCount++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request for one cycle: 0 acknowledge, 1 completion, 2 primary write
  task automatic pulse(input int sel);
    @(posedge core_clk) begin
      ackReq          <= (sel == 0);
      eoiReq          <= (sel == 1);
      primaryEoiWrite <= (sel == 2);
    end
    @(posedge core_clk) {ackReq, eoiReq, primaryEoiWrite} <= 3'h0;
    // Let the sequencer leave idle before watching busy
    @(negedge core_clk);
    for (int i = 0; i < 20 && (busy === 1'b1 || ackDone === 1'b1); i++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
  endtask
  // Acknowledge, then complete when pv is set, expectations from the field rules
  task automatic ack_eoi(input logic [9:0] id, input logic [2:0] cpu, input logic pv, ctl, md);
    logic [2:0] ec;
    int a0, d0, x0, n0;
    ec = (id <= 10'h00F) ? cpu : 3'h0;
    {a0, d0, x0, n0} = {nAck, nDrop, nDeact, nDone};
    @(posedge core_clk);
    {pendId, pendCpu, pendValid, ackControl, secMode} <= {id, cpu, pv, ctl, md};
    pulse(0);
    chk(ackValue, pv ? {ec, id} : 32'h3FF);
    chk(nAck - a0, pv);
    chk(nDone - n0, 32'h1);
    if (pv) begin
      chk({ackCpu, ackId}, {ec, id});
      pulse(1);
      chk({eoiCpu, eoiId}, {ec, id});
      chk(nDrop - d0, !ctl);
      chk(nDeact - x0, !ctl && !md);
    end
  endtask
  task automatic soft_completion();
    ack_eoi(10'h005, 3'h3, 1'b1, 1'b0, 1'b0);
    ack_eoi(10'h00F, 3'h7, 1'b1, 1'b0, 1'b1);
  endtask
  task automatic other_completion();
    ack_eoi(10'h010, 3'h7, 1'b1, 1'b0, 1'b0);
    ack_eoi(10'h3FE, 3'h5, 1'b1, 1'b1, 1'b0);
    ack_eoi(10'h020, 3'h1, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic primary_completion();
    int d0, g0;
    {d0, g0} = {nDrop, nG0};
    pulse(2);
    chk(nG0 - g0, 32'h1);
    chk(nDrop - d0, 32'h0);
  endtask
  task automatic print_verdict();
    $display("mismatches=%0d comparisons=%0d", badCount, testsRun);
    if (badCount == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {rstn, ackReq, eoiReq, pendValid, ackControl, secMode, primaryEoiWrite} = 7'h00;
    {pendId, pendCpu} = 13'h0000;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    soft_completion();
    other_completion();
    primary_completion();
    print_verdict();
  end
endmodule

// ### shared/galias_if.sv
interface galias_if;
  logic        rdEn;
  logic        wrEn;
  logic        secure;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        rvalid;

  modport device (
    input  rdEn,
    input  wrEn,
    input  secure,
    input  addr,
    input  wdata,
    output rdata,
    output rvalid
  );

  modport host (
    output rdEn,
    output wrEn,
    output secure,
    output addr,
    output wdata,
    input  rdata,
    input  rvalid
  );
endinterface

// ### shared/galias_pkg.sv
package galias_pkg;
  typedef enum logic [1:0] {
    GALIAS_IDLE,
    GALIAS_READ,
    GALIAS_WRITE
  } galias_host_state_t;
endpackage

// ### shared/galias_regs.svh
`ifndef GALIAS_REGS_SVH
`define GALIAS_REGS_SVH

// Word offsets of the two alias registers on the CPU interface port
`define GALIAS_ACK_OFFSET        12'h00C
`define GALIAS_EOI_OFFSET        12'h010
// Field positions
`define GALIAS_ID_LSB            0
`define GALIAS_ID_MSB            9
`define GALIAS_CPU_LSB           10
`define GALIAS_CPU_MSB           12
// Highest software-generated interrupt ID
`define GALIAS_SOFT_MAX_ID       10'h00F
// Spurious ID returned when nothing is signalled
`define GALIAS_SPURIOUS_ID       10'h3FF
// Reset value of the read data register
`define GALIAS_RDATA_RESET       32'h0000_0000

`endif

// ### src/galias_device.sv
`include "galias_regs.svh"

// Behaviour
// - Software interrupt acknowledge returns ID and requester CPU
// - Other acknowledges return zero requester field
// - Acknowledge control zero: alias write drops priority
// - Completion mode zero: alias write also deactivates
// - Secure primary completion never touches group1 priorities
// - Software completes most recent group1 acknowledge
// - Alias write uses secure completion mode bit
// - Alias completion accepted from secure accesses only
// - Software returns software interrupt requester unchanged
// - Software writes zero requester for other interrupts
// - Software writes acknowledged ID to ID field
// - Only last acknowledged value may be written
// - Alias acknowledge read acknowledges the interrupt
module galias_device (
  input  wire logic  core_clk,
  input  wire logic  rstn,
  input  wire logic  clkEn,
  galias_if.device   bus,
  input  wire logic  pendValid,
  input  wire logic  [9:0] pendId,
  input  wire logic  [2:0] pendCpu,
  input  wire logic  ackControl,
  input  wire logic  secureCompletionMode,
  input  wire logic  primaryEoiWrite,
  output logic       ackPulse,
  output logic [9:0] ackId,
  output logic [2:0] ackCpu,
  output logic       dropPulse,
  output logic       deactPulse,
  output logic [9:0] eoiId,
  output logic [2:0] eoiCpu,
  output logic       group0DropPulse
);

  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  logic        ackRead;
  logic        eoiWrite;
  logic        isSoftInt;
  logic [31:0] ackWord;

  // Alias registers act on secure accesses only
  assign ackRead  = clkEn && bus.rdEn && bus.secure &&
                    (bus.addr == `GALIAS_ACK_OFFSET);
  assign eoiWrite = clkEn && bus.wrEn && bus.secure &&
                    (bus.addr == `GALIAS_EOI_OFFSET);
  assign isSoftInt = pendId <= `GALIAS_SOFT_MAX_ID;

  // Assemble acknowledge word
  always_comb begin
    ackWord = 32'h0000_0000;
    if (pendValid) begin
      ackWord[`GALIAS_ID_MSB:`GALIAS_ID_LSB] = pendId;
      ackWord[`GALIAS_CPU_MSB:`GALIAS_CPU_LSB] =
        isSoftInt ? pendCpu : 3'h0;
    end else begin
      ackWord[`GALIAS_ID_MSB:`GALIAS_ID_LSB] = `GALIAS_SPURIOUS_ID;
    end
  end

  // --------------------------------------------------------------
  // Read data path
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      bus.rdata  <= `GALIAS_RDATA_RESET;
      bus.rvalid <= 1'b0;
    end else if (clkEn) begin
      bus.rvalid <= bus.rdEn;
      // Unmapped or non-secure reads return zero
      bus.rdata  <= ackRead ? ackWord : 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------
  // Acknowledge event
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ackPulse <= 1'b0;
      ackId    <= 10'h000;
      ackCpu   <= 3'h0;
    end else if (clkEn) begin
      ackPulse <= ackRead && pendValid;
      if (ackRead && pendValid) begin
        ackId  <= pendId;
        ackCpu <= isSoftInt ? pendCpu : 3'h0;
      end
    end
  end

  // --------------------------------------------------------------
  // Completion event
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dropPulse  <= 1'b0;
      deactPulse <= 1'b0;
      eoiId      <= 10'h000;
      eoiCpu     <= 3'h0;
    end else if (clkEn) begin
      dropPulse  <= eoiWrite && !ackControl;
      deactPulse <= eoiWrite && !ackControl &&
                    !secureCompletionMode;
      if (eoiWrite) begin
        // Reserved bits dropped here
        eoiId  <= bus.wdata[`GALIAS_ID_MSB:`GALIAS_ID_LSB];
        eoiCpu <= bus.wdata[`GALIAS_CPU_MSB:`GALIAS_CPU_LSB];
      end
    end
  end

  // --------------------------------------------------------------
  // Secure primary completion goes to group 0 only
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      group0DropPulse <= 1'b0;
    end else if (clkEn) begin
      group0DropPulse <= primaryEoiWrite;
    end
  end

endmodule

// ### src/galias_host.sv
`include "galias_regs.svh"

module galias_host (
  input  wire logic  core_clk,
  input  wire logic  rstn,
  input  wire logic  clkEn,
  galias_if.host     bus,
  input  wire logic  ackReq,
  input  wire logic  eoiReq,
  output logic       busy,
  output logic       ackDone,
  output logic [31:0] ackValue
);

  galias_pkg::galias_host_state_t state_reg;
  logic [31:0]                    lastAck_reg;

  // Bus signals from state
  assign bus.secure = 1'b1;
  assign bus.rdEn   = (state_reg == galias_pkg::GALIAS_READ) && !bus.rvalid;
  assign bus.wrEn   = (state_reg == galias_pkg::GALIAS_WRITE);
  assign bus.addr   = (state_reg == galias_pkg::GALIAS_WRITE) ?
                      `GALIAS_EOI_OFFSET : `GALIAS_ACK_OFFSET;
  // Completion echoes the last acknowledge word
  assign bus.wdata  = lastAck_reg;
  assign busy       = (state_reg != galias_pkg::GALIAS_IDLE);

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= galias_pkg::GALIAS_IDLE;
    end else if (clkEn) begin
      case (state_reg)
        galias_pkg::GALIAS_IDLE: begin
          if (ackReq) begin
            state_reg <= galias_pkg::GALIAS_READ;
          end else if (eoiReq) begin
            state_reg <= galias_pkg::GALIAS_WRITE;
          end
        end
        galias_pkg::GALIAS_READ: begin
          if (bus.rvalid) begin
            state_reg <= galias_pkg::GALIAS_IDLE;
          end
        end
        galias_pkg::GALIAS_WRITE: begin
          state_reg <= galias_pkg::GALIAS_IDLE;
        end
        default: begin
          state_reg <= galias_pkg::GALIAS_IDLE;
        end
      endcase
    end
  end

  // Capture acknowledge word
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lastAck_reg <= 32'h0000_0000;
      ackDone     <= 1'b0;
      ackValue    <= 32'h0000_0000;
    end else if (clkEn) begin
      ackDone <= (state_reg == galias_pkg::GALIAS_READ) && bus.rvalid;
      if ((state_reg == galias_pkg::GALIAS_READ) && bus.rvalid) begin
        lastAck_reg <= {19'h00000, bus.rdata[12:0]};
        ackValue    <= bus.rdata;
      end
    end
  end

endmodule
